/* hw/mmq_top.sv */
// motion move queue: per-task buffers, pending and active slot per axis
// assumes apb master on clk_sys and an external profiler signalling done
//
// Overview of operation
// - each axis has one active slot and one pending slot
// - active slot kind readable per axis; forward move reports ten
// - pending slot kind readable per axis
// - pending move starts only after the active move completes
// - axes move independently unless one move names several axes
// - a posted move waits until all its axes' pending slots are empty
// - per-task full flag set while buffer full, cleared when free
// - on each tick check free pending slots, then waiting task moves
// - accepted move copied to all named pending slots; task buffer idle
// - after sequencing, free active slots take the pending move
// - moving pending to active marks those pending slots idle
// - active move runs until done, then its slot goes idle
// - servo tick period is 0.5 or 1.0 ms by a setting
// - task-to-slot transfer is the first step of each period
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module mmq_top
    import mmq_pkg::*;
#(
    parameter int SHORT_CYC = TICK_SHORT_CYC,
    parameter int LONG_CYC  = TICK_LONG_CYC
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // apb
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    // motion side
    output logic [NUM_AXES-1:0]       active_valid,
    output logic [NUM_AXES*DATA_W-1:0] active_data,
    output logic                      servo_tick,
    // interrupt
    output logic                      irq
);
    typedef enum logic [1:0] {PH_WAIT, PH_SEQ, PH_LOAD} mmq_phase_t;

    mmq_phase_t                phase_q;
    mmq_apb_req_t              req;
    logic                      wr_en;
    logic                      rd_en;
    logic                      addr_ok;
    logic                      tick;
    logic [31:0]               ctrl_q;
    logic [31:0]               post_data_q;
    mmq_move_t                 task_q    [NUM_TASKS];
    logic [NUM_TASKS-1:0]      task_vld_q;
    mmq_move_t                 pend_q    [NUM_AXES];
    mmq_move_t                 act_q     [NUM_AXES];
    logic [NUM_AXES-1:0]       done_q;
    logic [NUM_TASKS-1:0]      full_flag;
    logic [1:0]                rr_q;
    logic [3:0]                irq_stat_q;
    logic [3:0]                irq_mask_q;
    logic [3:0]                irq_ev;
    logic                      seq_fire;
    logic [1:0]                seq_task;
    logic [NUM_AXES-1:0]       load_axes;
    logic [NUM_AXES-1:0]       pend_busy;
    logic [NUM_AXES-1:0]       act_busy;
    logic                      post_wr;
    logic [1:0]                post_task;

    // axes that a move names, or none when the slot is idle
    function automatic logic [NUM_AXES-1:0] axes_of(mmq_move_t m);
        return (m.kind == KIND_IDLE) ? '0 : m.axes;
    endfunction

    // servo tick source
    mmq_tick_gen #(
        .SHORT_CYC  (SHORT_CYC),
        .LONG_CYC   (LONG_CYC)
    ) u_tick (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .clk_en      (clk_en),
        .long_period (ctrl_q[0]),
        .tick        (tick)
    );

    // register bus front end
    mmq_apb_slave u_apb (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pready  (pready),
        .pslverr (pslverr),
        .req     (req),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .addr_ok (addr_ok)
    );

    // address decode
    always_comb begin
        unique case (req.addr)
            REG_CTRL, REG_POST, REG_POST_DATA, REG_DONE, REG_FULL,
            REG_ACT_KIND, REG_PEND_KIND, REG_IRQ_STAT,
            REG_IRQ_MASK: addr_ok = 1'b1;
            default:      addr_ok = 1'b0;
        endcase
    end

    assign servo_tick = tick;
    assign post_wr    = wr_en && req.addr == REG_POST && clk_en;
    assign post_task  = req.wdata[POST_TASK_LSB +: 2];

    // busy masks of both slot stages
    always_comb begin
        pend_busy = '0;
        act_busy  = '0;
        for (int a = 0; a < NUM_AXES; a++) begin
            pend_busy |= axes_of(pend_q[a]);
            act_busy  |= axes_of(act_q[a]);
        end
    end

    // per-task full flag: a posted move not yet sequenced
    assign full_flag = task_vld_q;

    // tick phase: sequencing first, then move loading
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_q <= PH_WAIT;
        end else if (clk_en) begin
            unique case (phase_q)
                PH_WAIT: if (tick) phase_q <= PH_SEQ;
                PH_SEQ:  phase_q <= PH_LOAD;
                PH_LOAD: phase_q <= PH_WAIT;
                default: phase_q <= PH_WAIT;
            endcase
        end
    end

    // pick the next waiting task whose axes have free pending slots
    always_comb begin
        logic [1:0] t;
        t        = '0;
        seq_fire = 1'b0;
        seq_task = '0;
        for (int i = 0; i < NUM_TASKS; i++) begin
            t = 2'(rr_q + 2'(i));
            if (!seq_fire && task_vld_q[t] &&
                (task_q[t].axes & pend_busy) == '0) begin
                seq_fire = 1'b1;
                seq_task = t;
            end
        end
        if (phase_q != PH_SEQ) begin
            seq_fire = 1'b0;
        end
    end

    // task buffers: post from software, freed by sequencing
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            task_vld_q <= '0;
            rr_q       <= '0;
            for (int i = 0; i < NUM_TASKS; i++) begin
                task_q[i] <= '0;
            end
        end else if (clk_en) begin
            if (seq_fire) begin
                task_vld_q[seq_task] <= 1'b0;
                rr_q <= 2'(seq_task + 2'h1);
            end
            // a post to a full task buffer is dropped; the task must stall
            if (post_wr && !task_vld_q[post_task] &&
                req.wdata[POST_AXES_LSB +: NUM_AXES] != '0) begin
                task_vld_q[post_task] <= 1'b1;
                task_q[post_task] <= '{
                    kind: req.wdata[POST_KIND_LSB +: KIND_W],
                    axes: req.wdata[POST_AXES_LSB +: NUM_AXES],
                    data: post_data_q[DATA_W-1:0]};
            end
        end
    end

    // load mask: every axis of a pending move must have a free active slot
    always_comb begin
        load_axes = '0;
        for (int a = 0; a < NUM_AXES; a++) begin
            if (pend_q[a].kind != KIND_IDLE &&
                (pend_q[a].axes & act_busy) == '0) begin
                load_axes[a] = 1'b1;
            end
        end
        if (phase_q != PH_LOAD) begin
            load_axes = '0;
        end
    end

    // pending slots, one per axis
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int a = 0; a < NUM_AXES; a++) begin
                pend_q[a] <= '0;
            end
        end else if (clk_en) begin
            for (int a = 0; a < NUM_AXES; a++) begin
                if (seq_fire && task_q[seq_task].axes[a]) begin
                    pend_q[a] <= task_q[seq_task];
                end else if (load_axes[a]) begin
                    pend_q[a] <= '0;
                end
            end
        end
    end

    // active slots, one per axis, each finishing on its own
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int a = 0; a < NUM_AXES; a++) begin
                act_q[a] <= '0;
            end
        end else if (clk_en) begin
            for (int a = 0; a < NUM_AXES; a++) begin
                if (load_axes[a]) begin
                    act_q[a] <= pend_q[a];
                end else if (done_q[a]) begin
                    act_q[a] <= '0;
                end
            end
        end
    end

    // completion strobes written by the profiler side, one per axis
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_q <= '0;
        end else if (clk_en) begin
            done_q <= '0;
            if (wr_en && req.addr == REG_DONE) begin
                done_q <= req.wdata[NUM_AXES-1:0] & act_busy;
            end
        end
    end

    // control and post data registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q      <= CTRL_RESET;
            post_data_q <= '0;
            irq_mask_q  <= MASK_RESET;
        end else if (clk_en && wr_en) begin
            if (req.addr == REG_CTRL) ctrl_q <= req.wdata;
            if (req.addr == REG_POST_DATA) post_data_q <= req.wdata;
            if (req.addr == REG_IRQ_MASK) irq_mask_q <= req.wdata[3:0];
        end
    end

    // motion outputs from the active slots
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            active_valid <= '0;
            active_data  <= '0;
        end else if (clk_en) begin
            for (int a = 0; a < NUM_AXES; a++) begin
                active_valid[a] <= act_q[a].kind != KIND_IDLE;
                active_data[a*DATA_W +: DATA_W] <= act_q[a].data;
            end
        end
    end

    // interrupt status: sticky, set wins over the read clear
    assign irq_ev = {post_wr && task_vld_q[post_task], |done_q,
                     |load_axes, seq_fire};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else if (clk_en) begin
            if (rd_en && req.addr == REG_IRQ_STAT) begin
                irq_stat_q <= irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // read data mux
    always_comb begin
        prdata = '0;
        if (rd_en) begin
            unique case (req.addr)
                REG_CTRL:      prdata = ctrl_q;
                REG_POST_DATA: prdata = post_data_q;
                REG_FULL:      prdata = {28'h0, full_flag};
                REG_ACT_KIND:  prdata = {act_q[3].kind, act_q[2].kind,
                                         act_q[1].kind, act_q[0].kind};
                REG_PEND_KIND: prdata = {pend_q[3].kind, pend_q[2].kind,
                                         pend_q[1].kind, pend_q[0].kind};
                REG_IRQ_STAT:  prdata = {28'h0, irq_stat_q};
                REG_IRQ_MASK:  prdata = {28'h0, irq_mask_q};
                default:       prdata = '0;
            endcase
        end
    end

    // sequencing only in the first step after a tick
    sequence s_tick_seq;
        tick && clk_en ##1 clk_en;
    endsequence
    a_seq_after_tick: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        seq_fire |-> phase_q == PH_SEQ)
        else $error("sequencing outside its phase");
    a_load_after_seq: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        |load_axes |-> $past(phase_q) == PH_SEQ || !$past(clk_en))
        else $error("loading before sequencing");
    a_phase_order: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_tick_seq |-> phase_q == PH_SEQ)
        else $error("tick did not start sequencing");
    a_load_needs_free: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (load_axes & act_busy) == '0)
        else $error("move loaded over a busy active slot");
    a_pend_cleared: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && load_axes[0] && !seq_fire |=>
            pend_q[0].kind == KIND_IDLE)
        else $error("pending slot not idle after load");
    a_task_freed: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && seq_fire && !post_wr |=> !task_vld_q[$past(seq_task)])
        else $error("task buffer not freed");
    a_full_flag: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && post_wr && !task_vld_q[post_task] && !seq_fire &&
        req.wdata[POST_AXES_LSB +: NUM_AXES] != '0 |=>
            full_flag[$past(post_task)])
        else $error("full flag not raised");
    a_done_idle: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && done_q[0] && !load_axes[0] |=> act_q[0].kind == KIND_IDLE)
        else $error("active slot not idle after done");
    // reset empties the slots and the task buffers within one edge
    a_idle_kind: assert property (
        @(posedge clk_sys)
        !rst_n |=> act_q[0].kind == KIND_IDLE &&
            pend_q[0].kind == KIND_IDLE && task_vld_q == '0)
        else $error("slot not idle after reset");
endmodule

/* hw/mmq_pkg.sv */
// package for the motion move queue: sizes, register map, move kinds
// assumes a 100 MHz system clock and a 32-bit APB register bus
package mmq_pkg;

    localparam int NUM_AXES  = 4;
    localparam int NUM_TASKS = 4;
    localparam int KIND_W    = 8;
    localparam int DATA_W    = 24;

    // move kind codes
    localparam logic [7:0] KIND_IDLE    = 8'h00;
    localparam logic [7:0] KIND_ARC     = 8'h04;
    localparam logic [7:0] KIND_FORWARD = 8'h0a;

    // servo tick timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TICK_SHORT_US   = 500;
    localparam int TICK_LONG_US    = 1000;
    localparam int TICK_SHORT_CYC  = TICK_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int TICK_LONG_CYC   = TICK_LONG_US * 1000 / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_POST      = 12'h004;
    localparam logic [11:0] REG_POST_DATA = 12'h008;
    localparam logic [11:0] REG_DONE      = 12'h00c;
    localparam logic [11:0] REG_FULL      = 12'h010;
    localparam logic [11:0] REG_ACT_KIND  = 12'h014;
    localparam logic [11:0] REG_PEND_KIND = 12'h018;
    localparam logic [11:0] REG_IRQ_STAT  = 12'h01c;
    localparam logic [11:0] REG_IRQ_MASK  = 12'h020;

    // post register fields
    localparam int POST_KIND_LSB = 0;
    localparam int POST_AXES_LSB = 8;
    localparam int POST_TASK_LSB = 16;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [3:0]  MASK_RESET = 4'h0;

    // interrupt status bits
    localparam int IRQ_SEQ  = 0;
    localparam int IRQ_LOAD = 1;
    localparam int IRQ_DONE = 2;
    localparam int IRQ_FULL = 3;

    // one queued or running move
    typedef struct packed {
        logic [7:0]  kind;
        logic [3:0]  axes;
        logic [23:0] data;
    } mmq_move_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } mmq_apb_req_t;

endpackage

/* hw/mmq_tick_gen.sv */
// servo tick generator: one pulse each servo period
// assumes clk_sys at 100 MHz; long_period picks 1.0 ms over 0.5 ms
`timescale 1ns/1ps
module mmq_tick_gen
    import mmq_pkg::*;
#(
    parameter int SHORT_CYC = TICK_SHORT_CYC,
    parameter int LONG_CYC  = TICK_LONG_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // control
    input  wire logic long_period,
    // tick out
    output logic      tick
);
    logic [17:0] cnt_q;
    logic [17:0] limit;

    // terminal count for the chosen period
    assign limit = long_period ? 18'(LONG_CYC - 1) : 18'(SHORT_CYC - 1);

    // period counter
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (cnt_q >= limit) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 18'h1;
            end
        end
    end

    assign tick = clk_en && (cnt_q >= limit);

    // a tick in the long setting lands on the long terminal count
    a_tick_period: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        tick && long_period |-> cnt_q == 18'(LONG_CYC - 1))
        else $error("long period tick off its terminal count");
endmodule

/* hw/mmq_apb_slave.sv */
// apb slave front end: takes the address decode from the top, one wait-free access phase
// assumes a standard apb master on clk_sys
`timescale 1ns/1ps
module mmq_apb_slave
    import mmq_pkg::*;
(
    // apb pins
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    // decoded access
    output mmq_apb_req_t     req,
    output logic             wr_en,
    output logic             rd_en,
    input  wire logic        addr_ok
);
    // pack the request and form the access strobes
    assign req     = '{sel: psel, enable: penable, write: pwrite,
                       addr: paddr, wdata: pwdata};
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && penable && !pwrite && addr_ok;
endmodule

/* test/mmq_task_model.sv */
// program task model: apb master that posts moves like a running program
// assumes a zero or few wait state apb slave on clk_sys
`timescale 1ns/1ps
module mmq_task_model
    import mmq_pkg::*;
(
    // clock
    input  wire logic        clk_sys,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // one apb transfer; request held until pready seen at an edge
    task automatic apb_xfer(input logic wr, input logic [11:0] a,
                            input logic [31:0] wd, output logic [31:0] rd,
                            output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // post a move: stall while this task's buffer is full, then issue it
    task automatic post_move(input logic [1:0] tsk, input logic [3:0] axes,
                             input logic [7:0] kind, input logic [23:0] data);
        logic [31:0] d;
        logic        e;
        do begin
            apb_xfer(1'b0, REG_FULL, 32'h0, d, e);
        end while (d[tsk] !== 1'b0);
        apb_xfer(1'b1, REG_POST_DATA, {8'h00, data}, d, e);
        apb_xfer(1'b1, REG_POST, {14'h0, tsk, 4'h0, axes, kind}, d, e);
    endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the move queue: program model posts moves,
// software completes them through the done register; short servo periods
`timescale 1ns/1ps
module testbench;
    import mmq_pkg::*;
    localparam int SIM_SHORT = 20;
    localparam int SIM_LONG  = 40;

    logic                       clk_sys = 1'b0;
    logic                       rst_n   = 1'b0;
    logic                       clk_en  = 1'b1;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [11:0]                paddr;
    logic [31:0]                pwdata;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    logic [NUM_AXES-1:0]        active_valid;
    logic [NUM_AXES*DATA_W-1:0] active_data;
    logic                       servo_tick;
    logic                       irq;
    int                         num_errors = 0;
    int                         compares   = 0;

    // clock
    always #5 clk_sys = ~clk_sys;

    mmq_task_model prog (
        .clk_sys (clk_sys), .psel (psel), .penable (penable),
        .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata),
        .pready (pready), .pslverr (pslverr), .prdata (prdata)
    );

    mmq_top #(.SHORT_CYC(SIM_SHORT), .LONG_CYC(SIM_LONG)) dut (
        .clk_sys (clk_sys), .rst_n (rst_n), .clk_en (clk_en),
        .psel (psel), .penable (penable), .pwrite (pwrite),
        .paddr (paddr), .pwdata (pwdata), .pready (pready),
        .pslverr (pslverr), .prdata (prdata),
        .active_valid (active_valid), .active_data (active_data),
        .servo_tick (servo_tick), .irq (irq)
    );

    task automatic close_out;
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        prog.apb_xfer(1'b0, a, 32'h0, d, e);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic        e;
        prog.apb_xfer(1'b1, a, v, d, e);
    endtask

    // wait for the next sampled tick, bounded
    task automatic wait_tick;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (servo_tick !== 1'b1 && n < 100);
        chk(servo_tick, 32'h1);
    endtask

    // one tick, then let sequencing and loading settle
    task automatic tick_settle;
        wait_tick();
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic t_reset;
        chk(active_valid, 32'h0);
        chk(irq, 32'h0);
        rd_chk(REG_ACT_KIND, 32'h0);
        rd_chk(REG_PEND_KIND, 32'h0);
        rd_chk(REG_FULL, 32'h0);
        rd_chk(REG_CTRL, CTRL_RESET);
        rd_chk(REG_IRQ_MASK, {28'h0, MASK_RESET});
    endtask

    task automatic t_single;
        wait_tick();
        prog.post_move(2'd0, 4'h1, KIND_FORWARD, 24'h123456);
        rd_chk(REG_FULL, 32'h1);
        rd_chk(REG_ACT_KIND, 32'h0);
        tick_settle();
        rd_chk(REG_ACT_KIND, 32'h0000_000a);
        rd_chk(REG_PEND_KIND, 32'h0);
        rd_chk(REG_FULL, 32'h0);
        chk(active_valid, 32'h1);
        chk(active_data[0 +: DATA_W], 32'h123456);
    endtask

    task automatic t_queue;
        logic [31:0] d;
        prog.post_move(2'd1, 4'h1, KIND_ARC, 24'h0000aa);
        tick_settle();
        rd_chk(REG_PEND_KIND, 32'h0000_0004);
        rd_chk(REG_ACT_KIND, 32'h0000_000a);
        prog.post_move(2'd2, 4'h1, KIND_FORWARD, 24'h0000bb);
        tick_settle();
        rd_chk(REG_FULL, 32'h4);
        rd_chk(REG_PEND_KIND, 32'h0000_0004);
        // post into a full buffer raises the masked interrupt
        wr(REG_IRQ_MASK, 32'h8);
        wr(REG_POST, {14'h0, 2'd2, 4'h0, 4'h1, KIND_ARC});
        @(posedge clk_sys);
        chk(irq, 32'h1);
        rd(REG_IRQ_STAT, d);
        chk(d[IRQ_FULL], 32'h1);
        rd(REG_IRQ_STAT, d);
        chk(d[IRQ_FULL], 32'h0);
        chk(irq, 32'h0);
        wr(REG_IRQ_MASK, 32'h0);
        // complete the running move; arc loads, task two still waits
        wr(REG_DONE, 32'h1);
        tick_settle();
        rd_chk(REG_ACT_KIND, 32'h0000_0004);
        rd_chk(REG_PEND_KIND, 32'h0);
        rd_chk(REG_FULL, 32'h4);
        chk(active_data[0 +: DATA_W], 32'h0000aa);
        tick_settle();
        rd_chk(REG_PEND_KIND, 32'h0000_000a);
        rd_chk(REG_FULL, 32'h0);
    endtask

    task automatic t_indep;
        prog.post_move(2'd3, 4'h2, KIND_FORWARD, 24'h0000cc);
        tick_settle();
        rd_chk(REG_ACT_KIND, 32'h0000_0a04);
        chk(active_valid, 32'h3);
        chk(active_data[DATA_W +: DATA_W], 32'h0000cc);
    endtask

    // mid-run reset with moves running, queued and waiting in a task
    task automatic t_rerst;
        prog.post_move(2'd1, 4'h1, KIND_ARC, 24'h0000dd);
        rd_chk(REG_FULL, 32'h2);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk(active_valid, 32'h0);
        rd_chk(REG_ACT_KIND, 32'h0);
        rd_chk(REG_PEND_KIND, 32'h0);
        rd_chk(REG_FULL, 32'h0);
    endtask

    // low clock enable stops ticks and ignores register writes
    task automatic t_freeze;
        int n;
        n = 0;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (50) begin
            @(posedge clk_sys);
            if (servo_tick === 1'b1) n++;
        end
        chk(n, 32'h0);
        wr(REG_IRQ_MASK, 32'h5);
        clk_en <= 1'b1;
        rd_chk(REG_IRQ_MASK, 32'h0);
    endtask

    task automatic measure(input int exp);
        int n;
        wait_tick();
        wait_tick();
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (servo_tick !== 1'b1 && n < 200);
        chk(n, exp);
    endtask

    task automatic t_period;
        wr(REG_CTRL, 32'h1);
        measure(SIM_LONG);
        wr(REG_CTRL, 32'h0);
        measure(SIM_SHORT);
    endtask

    task automatic t_unmapped;
        logic [31:0] d;
        logic        e;
        prog.apb_xfer(1'b1, 12'h0f0, 32'hffff_ffff, d, e);
        chk(e, 32'h1);
        prog.apb_xfer(1'b0, 12'h0f0, 32'h0, d, e);
        chk(e, 32'h1);
        rd_chk(REG_IRQ_MASK, 32'h0);
    endtask

    // watchdog
    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_single();
        t_queue();
        t_indep();
        t_rerst();
        t_period();
        t_freeze();
        t_unmapped();
        close_out();
    end
endmodule
